// ### design/aoc_consts.vh
// Purpose: Shared constants for the analog output channel control block
// Assumes: 10 MHz core clock, 16-bit configuration and cyclic words
// Notes: Word offsets are relative to the unit's configuration and cyclic areas
//
// Functional notes
// - Only channels one and two, each enabled separately
// - Cycle length is one millisecond per enabled channel
// - Fast high-resolution mode uses 500 us per channel
// - Disabled channel drives zero volts
// - Four selectable signal ranges per channel
// - Voltage or current chosen by separate word
// - New configuration loads only at power-up or restart
// - Out-of-range set value raises channel setting error
// - Timing/resolution from one word's upper byte, shared
// - Convert only while conversion enable bit set
// - Refuse conversion on adjust, error, fatal, disconnect
// - Enable bits cleared at power-on and program mode
// - Bus error, outputs off, watchdog also stop
// - Stop low byte: clear, keep last, maximum
// - Clear/maximum are -5%/+105%; bipolar clears zero
// - Current range holds 3.2 mA or 20.8 mA
// - Scaling maps user limits linearly onto resolution
// - Scaling only in standard resolution-4000 mode
// - Lower above upper gives inverted scaling
// - Converted output limited to -5% .. +105%
// - No scaling while ratio conversion in use
// - Bad limits flag error; both zero unscaled
// - Setting errors in status word bits zero, one
// - Channel with setting error follows hold behaviour
`ifndef AOC_CONSTS_VH
`define AOC_CONSTS_VH

// ----------------------------------------
// Configuration area word offsets
// ----------------------------------------
`define CFG_CH_ENABLE 6'h00
`define CFG_RANGE 6'h01
`define CFG_STOP1 6'h02
`define CFG_STOP2 6'h03
`define CFG_TIMING 6'h12
`define CFG_LOW1 6'h13
`define CFG_HIGH1 6'h14
`define CFG_LOW2 6'h15
`define CFG_HIGH2 6'h16
`define CFG_VI_SEL 6'h23

// ----------------------------------------
// Cyclic area word offsets
// ----------------------------------------
`define CYC_CONV_EN 4'h0
`define CYC_SET1 4'h1
`define CYC_SET2 4'h2
`define CYC_STATUS 4'h9

// ----------------------------------------
// Field codes and positions
// ----------------------------------------
`define RANGE_BIPOLAR 2'h0
`define RANGE_0_10 2'h1
`define RANGE_1_5 2'h2
`define RANGE_0_5 2'h3
`define HOLD_CLEAR 8'h00
`define HOLD_KEEP 8'h01
`define HOLD_MAX 8'h02
`define TIMING_FAST 8'hC1
`define RATIO_LSB 8
`define SCALE_ERR_LSB 8
`define SPAN_STD 16'h0FA0
`define SPAN_FAST 16'h1F40
`define LIMIT_MAX 17'h07D00
`define CFG_RESET 16'h0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 100
`define SLOT_STD_NS 1000000
`define SLOT_FAST_NS 500000

`endif

// ### design/output_scaler.v
// Purpose: Maps one channel's set value onto converter units and checks it
// Assumes: Purely combinational, span is the converter resolution
// Notes: Division is combinational; fine at 10 MHz, costly in area
`timescale 1ns/100ps
`include "aoc_consts.vh"
module output_scaler (
    input wire [15:0] set_i,
    input wire [15:0] lower_i,
    input wire [15:0] upper_i,
    input wire [15:0] span_i,
    input wire bipolar_i,
    input wire allow_i,
    output wire [15:0] code_o,
    output wire range_err_o,
    output wire cfg_err_o,
    output wire [15:0] clear_code_o,
    output wire [15:0] max_code_o,
    output wire [15:0] zero_code_o
);
    // ----------------------------------------
    // Limit checks
    // ----------------------------------------
    wire signed [16:0] v = {set_i[15], set_i};
    wire signed [16:0] lo = {lower_i[15], lower_i};
    wire signed [16:0] hi = {upper_i[15], upper_i};
    wire signed [16:0] lim = `LIMIT_MAX;
    wire both_zero = (lower_i == 16'h0000) && (upper_i == 16'h0000);
    wire lim_bad = (lo > lim) || (lo < -lim) || (hi > lim) || (hi < -lim);
    assign cfg_err_o = !both_zero && ((lower_i == upper_i) || lim_bad);
    wire scale_on = allow_i && !both_zero && !cfg_err_o;

    // ----------------------------------------
    // Linear mapping
    // ----------------------------------------
    wire signed [16:0] dv = v - lo;
    wire signed [16:0] den = hi - lo;
    wire signed [16:0] den_safe = (den == 17'h00000) ? 17'h00001 : den;
    wire signed [16:0] sp = {1'b0, span_i};
    wire signed [33:0] num = dv * sp;
    // Signed divide handles lower above upper as inverted scaling
    wire signed [33:0] quot = num / den_safe;
    wire signed [33:0] half = {18'h00000, 1'b0, span_i[15:1]};
    wire signed [33:0] five = {18'h00000, span_i / 16'h0014};
    wire signed [33:0] base = bipolar_i ? -half : 34'h000000000;
    wire signed [33:0] raw = scale_on ? (quot + base) : {{17{v[16]}}, v};

    // ----------------------------------------
    // Range window: -5% .. +105% of full scale
    // ----------------------------------------
    wire signed [33:0] win_lo = base - five;
    wire signed [33:0] win_hi = (bipolar_i ? half : {18'h00000, span_i}) + five;
    assign range_err_o = (raw < win_lo) || (raw > win_hi);
    wire signed [33:0] clamped = (raw < win_lo) ? win_lo : ((raw > win_hi) ? win_hi : raw);
    assign code_o = clamped[15:0];
    assign clear_code_o = bipolar_i ? 16'h0000 : win_lo[15:0];
    assign max_code_o = win_hi[15:0];
    assign zero_code_o = 16'h0000;
endmodule // output_scaler

// ### design/analog_output_channel_control.v
// Purpose: Two-channel analog output control: config, cycle, hold and status
// Assumes: Host logic on the same clock writes configuration and cyclic words
// Notes: Configuration writes land in a shadow and take effect on restart only
`timescale 1ns/100ps
`include "aoc_consts.vh"
module analog_output_channel_control #(
    parameter integer SLOT_STD_CYCLES = `SLOT_STD_NS / `CLK_PERIOD_NS,
    parameter integer SLOT_FAST_CYCLES = `SLOT_FAST_NS / `CLK_PERIOD_NS
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire cfg_wr_i,
    input wire [5:0] cfg_addr_i,
    input wire [15:0] cfg_wdata_i,
    input wire cyc_wr_i,
    input wire [3:0] cyc_addr_i,
    input wire [15:0] cyc_wdata_i,
    input wire [3:0] cyc_rd_addr_i,
    input wire unit_restart_i,
    input wire host_run_i,
    input wire host_fatal_i,
    input wire io_bus_error_i,
    input wire outputs_off_i,
    input wire host_watchdog_error_i,
    input wire adjust_mode_i,
    input wire [1:0] adjust_channel_i,
    input wire [1:0] ratio_disconnect_i,
    input wire [15:0] ratio1_value_i,
    input wire [15:0] ratio2_value_i,
    output reg [15:0] cyc_rdata_o,
    output reg [15:0] dac1_code_o,
    output reg [15:0] dac2_code_o,
    output reg [1:0] dac_update_o,
    output reg [3:0] range_sel_o,
    output reg [1:0] current_mode_o,
    output reg fast_mode_o,
    output reg [15:0] status_o
);
    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_SLOT1 = 3'b010;
    localparam [2:0] ST_SLOT2 = 3'b100;
    localparam integer STD_LAST = SLOT_STD_CYCLES - 1;
    localparam integer FAST_LAST = SLOT_FAST_CYCLES - 1;

    // Output after a slot: converted value or the chosen stop behaviour
    function [15:0] next_level;
        input ok;
        input [7:0] stop;
        input [15:0] code;
        input [15:0] prev;
        input [15:0] clr;
        input [15:0] mx;
        begin
            if (ok)
                next_level = code;
            else if (stop == `HOLD_KEEP)
                next_level = prev;
            else if (stop == `HOLD_MAX)
                next_level = mx;
            else
                next_level = clr;
        end
    endfunction

    // ----------------------------------------
    // Configuration shadow and active copies
    // ----------------------------------------
    reg [15:0] sh_enable;
    reg [15:0] sh_range;
    reg [15:0] sh_stop1;
    reg [15:0] sh_stop2;
    reg [15:0] sh_timing;
    reg [15:0] sh_low1;
    reg [15:0] sh_high1;
    reg [15:0] sh_low2;
    reg [15:0] sh_high2;
    reg [15:0] sh_vi;
    reg [15:0] act_enable;
    reg [15:0] act_range;
    reg [7:0] act_stop1;
    reg [7:0] act_stop2;
    reg [7:0] act_timing;
    reg [15:0] act_low1;
    reg [15:0] act_high1;
    reg [15:0] act_low2;
    reg [15:0] act_high2;
    reg [15:0] act_vi;
    reg load_pending;
    wire load_now = load_pending | unit_restart_i;

    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sh_enable <= `CFG_RESET;
            sh_range <= `CFG_RESET;
            sh_stop1 <= `CFG_RESET;
            sh_stop2 <= `CFG_RESET;
            sh_timing <= `CFG_RESET;
            sh_low1 <= `CFG_RESET;
            sh_high1 <= `CFG_RESET;
            sh_low2 <= `CFG_RESET;
            sh_high2 <= `CFG_RESET;
            sh_vi <= `CFG_RESET;
        end
        else if (cfg_wr_i)
        begin
            case (cfg_addr_i)
                `CFG_CH_ENABLE: sh_enable <= cfg_wdata_i;
                `CFG_RANGE: sh_range <= cfg_wdata_i;
                `CFG_STOP1: sh_stop1 <= cfg_wdata_i;
                `CFG_STOP2: sh_stop2 <= cfg_wdata_i;
                `CFG_TIMING: sh_timing <= cfg_wdata_i;
                `CFG_LOW1: sh_low1 <= cfg_wdata_i;
                `CFG_HIGH1: sh_high1 <= cfg_wdata_i;
                `CFG_LOW2: sh_low2 <= cfg_wdata_i;
                `CFG_HIGH2: sh_high2 <= cfg_wdata_i;
                `CFG_VI_SEL: sh_vi <= cfg_wdata_i;
                default: sh_vi <= sh_vi;
            endcase
        end
    end

    // Copy happens on the first edge after reset and on every restart
    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            load_pending <= 1'b1;
            act_enable <= `CFG_RESET;
            act_range <= `CFG_RESET;
            act_stop1 <= `HOLD_CLEAR;
            act_stop2 <= `HOLD_CLEAR;
            act_timing <= 8'h00;
            act_low1 <= `CFG_RESET;
            act_high1 <= `CFG_RESET;
            act_low2 <= `CFG_RESET;
            act_high2 <= `CFG_RESET;
            act_vi <= `CFG_RESET;
        end
        else
        begin
            load_pending <= 1'b0;
            if (load_now)
            begin
                act_enable <= sh_enable;
                act_range <= sh_range;
                act_stop1 <= sh_stop1[7:0];
                act_stop2 <= sh_stop2[7:0];
                act_timing <= sh_timing[15:8];
                act_low1 <= sh_low1;
                act_high1 <= sh_high1;
                act_low2 <= sh_low2;
                act_high2 <= sh_high2;
                act_vi <= sh_vi;
            end
        end
    end

    // ----------------------------------------
    // Decoded configuration
    // ----------------------------------------
    wire [1:0] ch_en = act_enable[1:0];
    wire fast = (act_timing == `TIMING_FAST);
    wire [15:0] span = fast ? `SPAN_FAST : `SPAN_STD;
    wire [1:0] rng1 = act_range[1:0];
    wire [1:0] rng2 = act_range[3:2];
    wire [1:0] ratio_on = act_enable[`RATIO_LSB+1:`RATIO_LSB];

    // ----------------------------------------
    // Cyclic words from the host
    // ----------------------------------------
    reg [1:0] conv_en;
    reg [15:0] set1;
    reg [15:0] set2;
    reg run_q;
    wire leave_run = run_q & ~host_run_i;

    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            conv_en <= 2'h0;
            set1 <= 16'h0000;
            set2 <= 16'h0000;
            run_q <= 1'b0;
        end
        else
        begin
            run_q <= host_run_i;
            // A host write in the same cycle beats the mode-change clear
            if (cyc_wr_i && cyc_addr_i == `CYC_CONV_EN)
                conv_en <= cyc_wdata_i[1:0];
            else if (leave_run)
                conv_en <= 2'h0;
            if (cyc_wr_i && cyc_addr_i == `CYC_SET1)
                set1 <= cyc_wdata_i;
            if (cyc_wr_i && cyc_addr_i == `CYC_SET2)
                set2 <= cyc_wdata_i;
        end
    end

    // ----------------------------------------
    // Per-channel scaling and range check
    // ----------------------------------------
    wire [15:0] code1;
    wire [15:0] code2;
    wire rerr1;
    wire rerr2;
    wire cerr1;
    wire cerr2;
    wire [15:0] clr1;
    wire [15:0] clr2;
    wire [15:0] max1;
    wire [15:0] max2;

    output_scaler u_scale1 (
        .set_i(ratio_on[0] ? ratio1_value_i : set1),
        .lower_i(act_low1),
        .upper_i(act_high1),
        .span_i(span),
        .bipolar_i(rng1 == `RANGE_BIPOLAR),
        .allow_i(!fast && !ratio_on[0]),
        .code_o(code1),
        .range_err_o(rerr1),
        .cfg_err_o(cerr1),
        .clear_code_o(clr1),
        .max_code_o(max1),
        .zero_code_o()
    );

    output_scaler u_scale2 (
        .set_i(ratio_on[1] ? ratio2_value_i : set2),
        .lower_i(act_low2),
        .upper_i(act_high2),
        .span_i(span),
        .bipolar_i(rng2 == `RANGE_BIPOLAR),
        .allow_i(!fast && !ratio_on[1]),
        .code_o(code2),
        .range_err_o(rerr2),
        .cfg_err_o(cerr2),
        .clear_code_o(clr2),
        .max_code_o(max2),
        .zero_code_o()
    );

    // Ratio results are clamped, not flagged, so only host set values err
    wire [1:0] set_err = {rerr2 & ~ratio_on[1], rerr1 & ~ratio_on[0]} & ch_en;
    // 1..5 V sits 1 V above zero: zero volts is a quarter span below origin
    wire [15:0] zv1 = (rng1 == `RANGE_1_5) ? (16'h0000 - {2'h0, span[15:2]}) : 16'h0000;
    wire [15:0] zv2 = (rng2 == `RANGE_1_5) ? (16'h0000 - {2'h0, span[15:2]}) : 16'h0000;

    // ----------------------------------------
    // Stop conditions
    // ----------------------------------------
    wire global_stop = host_fatal_i | io_bus_error_i | outputs_off_i | host_watchdog_error_i;
    wire [1:0] adj_block = adjust_mode_i ? ~adjust_channel_i : 2'h0;
    wire [1:0] disc_block = ratio_on & ratio_disconnect_i;
    // Setting errors also fall back to the hold behaviour
    wire [1:0] run_ok = conv_en & ch_en & ~set_err & ~adj_block & ~disc_block
                        & {2{~global_stop}};

    // ----------------------------------------
    // Conversion cycle sequencer
    // ----------------------------------------
    reg [2:0] state;
    reg [2:0] next_state;
    reg [15:0] slot_cnt;
    wire [15:0] slot_last = fast ? FAST_LAST[15:0] : STD_LAST[15:0];
    wire slot_done = (slot_cnt == slot_last);

    always @*
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (ch_en[0])
                    next_state = ST_SLOT1;
                else if (ch_en[1])
                    next_state = ST_SLOT2;
            ST_SLOT1:
                if (slot_done)
                    next_state = ch_en[1] ? ST_SLOT2 : (ch_en[0] ? ST_SLOT1 : ST_IDLE);
            ST_SLOT2:
                if (slot_done)
                    next_state = ch_en[0] ? ST_SLOT1 : (ch_en[1] ? ST_SLOT2 : ST_IDLE);
            default:
                next_state = ST_IDLE;
        endcase
        if (load_now)
            next_state = ST_IDLE;
    end

    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            state <= ST_IDLE;
            slot_cnt <= 16'h0000;
        end
        else
        begin
            state <= next_state;
            if (state == ST_IDLE || slot_done || load_now)
                slot_cnt <= 16'h0000;
            else
                slot_cnt <= slot_cnt + 16'h0001;
        end
    end

    // ----------------------------------------
    // Output levels
    // ----------------------------------------
    wire upd1 = (state == ST_SLOT1) && slot_done && !load_now;
    wire upd2 = (state == ST_SLOT2) && slot_done && !load_now;

    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            dac1_code_o <= 16'h0000;
            dac2_code_o <= 16'h0000;
            dac_update_o <= 2'h0;
        end
        else
        begin
            dac_update_o <= {upd2, upd1};
            if (!ch_en[0])
                dac1_code_o <= zv1;
            else if (upd1)
                dac1_code_o <= next_level(run_ok[0], act_stop1, code1, dac1_code_o, clr1, max1);
            if (!ch_en[1])
                dac2_code_o <= zv2;
            else if (upd2)
                dac2_code_o <= next_level(run_ok[1], act_stop2, code2, dac2_code_o, clr2, max2);
        end
    end

    // ----------------------------------------
    // Status and readback
    // ----------------------------------------
    always @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            status_o <= 16'h0000;
            cyc_rdata_o <= 16'h0000;
            range_sel_o <= 4'h0;
            current_mode_o <= 2'h0;
            fast_mode_o <= 1'b0;
        end
        else
        begin
            status_o <= {6'h00, cerr2, cerr1, 6'h00, set_err};
            range_sel_o <= {rng2, rng1};
            current_mode_o <= {(rng2 == `RANGE_1_5) & act_vi[1],
                               (rng1 == `RANGE_1_5) & act_vi[0]};
            fast_mode_o <= fast;
            case (cyc_rd_addr_i)
                `CYC_CONV_EN: cyc_rdata_o <= {14'h0000, conv_en};
                `CYC_SET1: cyc_rdata_o <= set1;
                `CYC_SET2: cyc_rdata_o <= set2;
                `CYC_STATUS: cyc_rdata_o <= {6'h00, cerr2, cerr1, 6'h00, set_err};
                default: cyc_rdata_o <= 16'h0000;
            endcase
        end
    end
endmodule // analog_output_channel_control

// ### dv/aoc_checker.sv
// Purpose: Port-level assertions for the analog output channel control
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Slot spacing is only judged between two updates with no restart between
`timescale 1ns/100ps
module aoc_checker #(
    parameter integer SLOT_STD_CYCLES = 20,
    parameter integer SLOT_FAST_CYCLES = 10
) (
    input wire core_clk_i,
    input wire rst_n_i,
    input wire cyc_wr_i,
    input wire [3:0] cyc_addr_i,
    input wire [15:0] cyc_wdata_i,
    input wire [3:0] cyc_rd_addr_i,
    input wire unit_restart_i,
    input wire host_run_i,
    input wire [15:0] cyc_rdata_o,
    input wire [15:0] dac1_code_o,
    input wire [1:0] dac_update_o,
    input wire [3:0] range_sel_o,
    input wire [1:0] current_mode_o,
    input wire fast_mode_o,
    input wire [15:0] status_o
);
reg [15:0] gap;
reg armed;
default clocking cb @(posedge core_clk_i);
endclocking
default disable iff (!rst_n_i);
// ----------------------------------------
// Cycles since the last update pulse
// ----------------------------------------
always @(posedge core_clk_i or negedge rst_n_i)
begin
    if (!rst_n_i)
    begin
        gap <= 16'h0000;
        armed <= 1'b0;
    end
    else
    begin
        gap <= (|dac_update_o) ? 16'h0000 : gap + 16'h0001;
        armed <= !unit_restart_i && (armed || (|dac_update_o));
    end
end
sequence s_run_exit; ($fell(host_run_i) && !cyc_wr_i && cyc_rd_addr_i == 4'h0) ##1 (!cyc_wr_i && cyc_rd_addr_i == 4'h0) [*2]; endsequence
sequence s_set_write; (cyc_wr_i && cyc_addr_i == 4'h1) ##1 (!cyc_wr_i && cyc_rd_addr_i == 4'h1); endsequence
property p_slot_gap; (|dac_update_o) && armed |-> gap == (fast_mode_o ? SLOT_FAST_CYCLES : SLOT_STD_CYCLES) - 1; endproperty
a_slot_gap: assert property (p_slot_gap) else $error("update spacing differs from slot length");
property p_one_slot; dac_update_o != 2'h3; endproperty
a_one_slot: assert property (p_one_slot) else $error("two channels updated at once");
property p_status_spare; (status_o & 16'hFCFC) == 16'h0000; endproperty
a_status_spare: assert property (p_status_spare) else $error("status spare bit set");
property p_range_gated; $changed(range_sel_o) |-> $past(unit_restart_i) || $past(unit_restart_i, 2); endproperty
a_range_gated: assert property (p_range_gated) else $error("range changed without restart");
property p_mode_gated; $changed({current_mode_o, fast_mode_o}) |-> $past(unit_restart_i) || $past(unit_restart_i, 2); endproperty
a_mode_gated: assert property (p_mode_gated) else $error("mode changed without restart");
property p_run_exit; s_run_exit |=> cyc_rdata_o[1:0] == 2'h0; endproperty
a_run_exit: assert property (p_run_exit) else $error("enables survive leaving run");
property p_set_readback; s_set_write |=> cyc_rdata_o == $past(cyc_wdata_i, 2); endproperty
a_set_readback: assert property (p_set_readback) else $error("set value readback wrong");
property p_unmapped; !(cyc_rd_addr_i inside {4'h0, 4'h1, 4'h2, 4'h9}) |=> cyc_rdata_o == 16'h0000; endproperty
a_unmapped: assert property (p_unmapped) else $error("unmapped word not zero");
property p_limit; !fast_mode_o |-> $signed(dac1_code_o) >= -2200 && $signed(dac1_code_o) <= 4200; endproperty
a_limit: assert property (p_limit) else $error("channel one code out of limits");
endmodule // aoc_checker
bind analog_output_channel_control aoc_checker #(.SLOT_STD_CYCLES(SLOT_STD_CYCLES),
    .SLOT_FAST_CYCLES(SLOT_FAST_CYCLES)) chk (.*);

// ### dv/host_cpu_model.sv
// Purpose: Host controller model writing configuration and cyclic words
// Assumes: Same clock as the unit, requests launched 1 ns after a rising edge
// Notes: Released data lines carry the inverse of the last word
`timescale 1ns/100ps
module host_cpu_model (
    input wire core_clk_i,
    output reg cfg_wr_o = 1'b0,
    output reg [5:0] cfg_addr_o = 6'h00,
    output reg [15:0] cfg_wdata_o = 16'h0000,
    output reg cyc_wr_o = 1'b0,
    output reg [3:0] cyc_addr_o = 4'h0,
    output reg [15:0] cyc_wdata_o = 16'h0000,
    output reg unit_restart_o = 1'b0,
    output reg host_run_o = 1'b1
);
// Configuration lands in the shadow only; restart is needed to use it
task cfg_write(input [5:0] a, input [15:0] d);
    begin
        @(posedge core_clk_i);
        #1 cfg_addr_o = a;
        cfg_wdata_o = d;
        cfg_wr_o = 1'b1;
        @(posedge core_clk_i);
        #1 cfg_wr_o = 1'b0;
        cfg_wdata_o = ~d;
    end
endtask
task cyc_write(input [3:0] a, input [15:0] d);
    begin
        @(posedge core_clk_i);
        #1 cyc_addr_o = a;
        cyc_wdata_o = d;
        cyc_wr_o = 1'b1;
        @(posedge core_clk_i);
        #1 cyc_wr_o = 1'b0;
        cyc_wdata_o = ~d;
    end
endtask
task restart;
    begin
        @(posedge core_clk_i);
        #1 unit_restart_o = 1'b1;
        @(posedge core_clk_i);
        #1 unit_restart_o = 1'b0;
    end
endtask
task set_run(input r);
    begin
        @(posedge core_clk_i);
        #1 host_run_o = r;
    end
endtask
endmodule // host_cpu_model

// ### dv/tb_analog_output_channel_control.sv
// Purpose: Self-checking bench for the analog output channel control
// Assumes: Slots shortened to 20/10 cycles, channel one on 0..10 V, span 4000
// Notes: Hold codes are FF38 (-5%) and 1068 (+105%); channel two stays disabled
`timescale 1ns/100ps
module tb_analog_output_channel_control;
reg core_clk_i = 1'b0;
reg rst_n_i = 1'b0;
reg [4:0] stop_v = 5'h00;
reg [3:0] rd_addr = 4'hF;
wire cfg_wr, cyc_wr, restart, run, fast_mode_o;
wire [5:0] cfg_addr;
wire [3:0] cyc_addr, range_sel_o;
wire [15:0] cfg_wdata, cyc_wdata, cyc_rdata_o, dac1_code_o, dac2_code_o, status_o;
wire [1:0] dac_update_o, current_mode_o;
integer mismatches = 0;
integer compares = 0;
integer i;
reg [15:0] v;
reg [15:0] exp_q[$];
always #50 core_clk_i = ~core_clk_i;
host_cpu_model host (.core_clk_i(core_clk_i), .cfg_wr_o(cfg_wr), .cfg_addr_o(cfg_addr), .cfg_wdata_o(cfg_wdata),
    .cyc_wr_o(cyc_wr), .cyc_addr_o(cyc_addr), .cyc_wdata_o(cyc_wdata), .unit_restart_o(restart), .host_run_o(run));
analog_output_channel_control #(.SLOT_STD_CYCLES(20), .SLOT_FAST_CYCLES(10)) DUT (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr), .cfg_wdata_i(cfg_wdata),
    .cyc_wr_i(cyc_wr), .cyc_addr_i(cyc_addr), .cyc_wdata_i(cyc_wdata), .cyc_rd_addr_i(rd_addr),
    .unit_restart_i(restart), .host_run_i(run), .host_fatal_i(stop_v[0]), .io_bus_error_i(stop_v[1]),
    .outputs_off_i(stop_v[2]), .host_watchdog_error_i(stop_v[3]), .adjust_mode_i(stop_v[4]),
    .adjust_channel_i(stop_v[4:3]), .ratio_disconnect_i(stop_v[1:0]), .ratio1_value_i(v), .ratio2_value_i(v),
    .cyc_rdata_o(cyc_rdata_o), .dac1_code_o(dac1_code_o), .dac2_code_o(dac2_code_o), .dac_update_o(dac_update_o),
    .range_sel_o(range_sel_o), .current_mode_o(current_mode_o), .fast_mode_o(fast_mode_o), .status_o(status_o));
task check(input [15:0] got, input [15:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task wait_upd;
    begin
        repeat (400)
        begin
            @(negedge core_clk_i);
            if (dac_update_o[0] === 1'b1)
                return;
        end
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, 16'h0000, 16'h0001);
    end
endtask
task expect1(input [15:0] e);
    begin
        wait_upd();
        @(posedge core_clk_i);
        #1 exp_q.push_back(e);
        wait_upd();
    end
endtask
task setv(input [15:0] d);
    host.cyc_write(4'h1, d);
endtask
task cfg_set(input [15:0] stop, input [15:0] lo, input [15:0] hi, input [15:0] tm);
    begin
        host.cfg_write(6'h02, stop);
        host.cfg_write(6'h13, lo);
        host.cfg_write(6'h14, hi);
        host.cfg_write(6'h12, tm);
        host.restart();
        host.cyc_write(4'h0, 16'h0001);
    end
endtask
task wrap_up;
    begin
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
endtask
// ----------------------------------------
// Result monitor
// ----------------------------------------
always @(posedge core_clk_i)
    if (dac_update_o[0] === 1'b1 && exp_q.size() > 0)
        check(dac1_code_o, exp_q.pop_front());
initial
begin
    repeat (20000) @(posedge core_clk_i);
    mismatches = mismatches + 1;
    wrap_up();
end
// ----------------------------------------
// Main sequence
// ----------------------------------------
initial
begin
    v = $urandom(32'h00f092a0);
    repeat (10) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    @(negedge core_clk_i);
    check(dac1_code_o, 16'h0000);
    check(cyc_rdata_o, 16'h0000);
    host.cfg_write(6'h00, 16'h0001);
    host.cfg_write(6'h01, 16'h0009);
    host.cfg_write(6'h23, 16'h0002);
    repeat (3) @(negedge core_clk_i);
    check({12'h000, range_sel_o}, 16'h0000);
    host.restart();
    repeat (3) @(negedge core_clk_i);
    check({12'h000, range_sel_o}, 16'h0009);
    check({14'h0000, current_mode_o}, 16'h0002);
    check(dac2_code_o, 16'hFC18);
    $display("test configuration done");
    @(posedge core_clk_i);
    #1 rd_addr = 4'h1;
    cfg_set(16'h1200, 16'h0000, 16'h0000, 16'h0000);
    setv(16'h07D0);
    expect1(16'h07D0);
    for (i = 0; i < 3; i = i + 1)
    begin
        v = $urandom % 4001;
        setv(v);
        expect1(v);
    end
    setv(16'h1194);
    expect1(16'hFF38);
    check(status_o, 16'h0001);
    setv(16'h03E8);
    expect1(16'h03E8);
    check(status_o, 16'h0000);
    host.cyc_write(4'h0, 16'h0000);
    expect1(16'hFF38);
    $display("test set values and errors done");
    cfg_set(16'hAB02, 16'h0000, 16'h0000, 16'h0000);
    for (i = 0; i < 5; i = i + 1)
    begin
        @(posedge core_clk_i);
        #1 stop_v = 5'h01 << i;
        expect1(16'h1068);
        @(posedge core_clk_i);
        #1 stop_v = 5'h00;
        expect1(16'h03E8);
    end
    host.cfg_write(6'h02, 16'h0001);
    @(posedge core_clk_i);
    #1 rd_addr = 4'h0;
    host.set_run(1'b0);
    expect1(16'h1068);
    check(cyc_rdata_o, 16'h0000);
    host.set_run(1'b1);
    cfg_set(16'h0001, 16'h0000, 16'h0000, 16'h0000);
    setv(16'h0BB8);
    expect1(16'h0BB8);
    host.cyc_write(4'h0, 16'h0000);
    expect1(16'h0BB8);
    $display("test stop behaviour done");
    @(posedge core_clk_i);
    #1 rd_addr = 4'h9;
    cfg_set(16'h0000, 16'h0000, 16'h2710, 16'h0000);
    setv(16'h1388);
    expect1(16'h07D0);
    cfg_set(16'h0000, 16'h2710, 16'h0000, 16'h0000);
    setv(16'h09C4);
    expect1(16'h0BB8);
    cfg_set(16'h0000, 16'h0064, 16'h0064, 16'h0000);
    setv(16'h03E8);
    expect1(16'h03E8);
    check(status_o, 16'h0100);
    cfg_set(16'h0000, 16'h0000, 16'h2710, 16'hC100);
    expect1(16'h03E8);
    check({15'h0000, fast_mode_o}, 16'h0001);
    host.cfg_write(6'h00, 16'h0101);
    cfg_set(16'h0002, 16'h0000, 16'h2710, 16'h0000);
    expect1(v);
    $display("test scaling done");
    wrap_up();
end
endmodule // tb_analog_output_channel_control
